// *** rtl/pes_pkg.sv ***
`default_nettype none
package pes_pkg;

   // Encoder type selector codes
   localparam logic [2:0] ENC_OFF     = 3'h0;
   localparam logic [2:0] ENC_T1      = 3'h1;
   localparam logic [2:0] ENC_T1A     = 3'h2;
   localparam logic [2:0] ENC_T2      = 3'h3;
   localparam logic [2:0] ENC_T3      = 3'h4;
   localparam logic [2:0] ENC_TYPE_RST = 3'h0;

   // Edge multiplicity selector codes
   localparam logic [1:0] MULT_1X     = 2'h0;
   localparam logic [1:0] MULT_2X     = 2'h1;
   localparam logic [1:0] MULT_4X     = 2'h2;
   localparam logic [1:0] MULT_RST    = 2'h2;

   // Measuring window selector codes
   localparam logic [1:0] WSEL_1MS    = 2'h0;
   localparam logic [1:0] WSEL_2MS    = 2'h1;
   localparam logic [1:0] WSEL_4MS    = 2'h2;

   // Software-side reset values of the settings
   localparam logic [14:0] PPR_RST    = 15'h01F4;
   localparam logic [15:0] MAXSPD_RST = 16'h1388;

   // Timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned WIN_UNIT_NS   = 1000000;
   localparam int unsigned WIN_UNIT_CYC  = WIN_UNIT_NS / CLK_PERIOD_NS;

   // Speed arithmetic: rpm_max * ppr, and its per-ms single-track edge limit
   localparam int unsigned NMAX_NUM          = 18000000;
   localparam int unsigned EDGE_LIMIT_PER_MS = NMAX_NUM / 60000;
   // 60000 ms/min * 10 (0.1 rpm) * 10000 (0.01 %)
   localparam logic [47:0] SPEED_SCALE = 48'h0001_65A0_BC00;
   localparam logic [14:0] MIN_EDGES   = 15'h0001;

   localparam int CNT_W = 15;
   localparam int TMR_W = 20;
   localparam int DIV_W = 48;

   typedef enum logic [2:0] {
      DV_IDLE = 3'b001,
      DV_RUN  = 3'b010,
      DV_DONE = 3'b100
   } pes_div_st_t;

endpackage
`default_nettype wire

// *** rtl/pes_edge_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface pes_edge_if;
   logic       trk_a;
   logic       trk_b;
   logic [1:0] mult;
   logic       edge_q;
   logic       up;
   logic       rise_a;
   modport qual (input trk_a, trk_b, mult, output edge_q, up, rise_a);
   modport core (output trk_a, trk_b, mult, input edge_q, up, rise_a);
endinterface
`default_nettype wire

// *** rtl/pes_edge_qual.sv ***
`timescale 1ns/1ns
`default_nettype none
module pes_edge_qual
   import pes_pkg::*;
(
   input  wire logic mclk,    // System clock
   input  wire logic sys_rst, // Async reset, high
   pes_edge_if.qual  eif      // Track samples in, qualified edges out
);
   logic prev_a_ff;
   logic prev_b_ff;
   logic prev_ok_ff;
   // No edge until one real sample is held, whatever level the tracks rest at
   wire  chg_a = prev_ok_ff & (eif.trk_a ^ prev_a_ff);
   wire  chg_b = prev_ok_ff & (eif.trk_b ^ prev_b_ff);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_a_ff <= 1'b0;
         prev_b_ff  <= 1'b0;
         prev_ok_ff <= 1'b0;
      end else begin
         prev_a_ff  <= eif.trk_a;
         prev_b_ff  <= eif.trk_b;
         prev_ok_ff <= 1'b1;
      end
   end

   assign eif.rise_a = chg_a & eif.trk_a;
   assign eif.edge_q = (eif.mult == MULT_4X) ? (chg_a | chg_b) :
                       (eif.mult == MULT_2X) ? chg_a :
                       eif.rise_a;
   // Track A leading track B counts up
   assign eif.up     = chg_a ? (eif.trk_a ^ eif.trk_b) : (eif.trk_a ~^ eif.trk_b);
endmodule
`default_nettype wire

// *** rtl/pes_speed.sv ***
// How it works
// - 1x counts rising edges of one track
// - 2x counts both edges, types 1/1a/2
// - 4x counts both tracks, types 1/1a
// - Multiplicity codes 0,1,2 mean 1x,2x,4x
// - Multiplicity governs speed and position paths
// - Type codes 0-4, 0 disables sensing
// - Pulses per revolution is the divisor
// - Maximum speed setting equals 100 percent
// - Below minimum measurable speed report zero
// - Max speed is 18000000 over pulses
// - Base window is 1 ms by default
// - Auto switchovers extend range at low speed
// - Window select 0/1/2 gives 1/2/4 ms
// - Auto window lengthens to 2/4 ms
`timescale 1ns/1ns
`default_nettype none
module pes_speed
   import pes_pkg::*;
#(
   parameter int unsigned WIN_1MS_CYC = WIN_UNIT_CYC, // Cycles per 1 ms window unit
   parameter int unsigned LOW_EDGES   = 16,           // Below this count speed is low
   parameter int unsigned VLOW_EDGES  = 4             // Below this count speed is very low
)(
   input  wire logic        mclk,                         // 100 MHz clock
   input  wire logic        sys_rst,                      // Async reset, high
   input  wire logic        track_a,                      // Encoder track A
   input  wire logic        track_b,                      // Encoder track B
   input  wire logic        gate_sync,                    // Gating-pulse sync strobe
   input  wire logic [2:0]  encoder_type_select,          // 0 off, 1..4 types
   input  wire logic [14:0] pulses_per_revolution,        // 1..32767
   input  wire logic [15:0] max_speed_setting,            // 0.1 rpm units
   input  wire logic [1:0]  edge_multiplicity_select,     // 0 1x, 1 2x, 2 4x
   input  wire logic        auto_multiplicity_switchover, // Raise multiplicity when slow
   input  wire logic        auto_window_switchover,       // Lengthen window when slow
   input  wire logic [1:0]  measuring_window_select,      // 0 1ms, 1 2ms, 2 4ms
   output logic [15:0]      actual_speed_percent,         // 0.01 % units, saturating
   output logic             speed_update,                 // Pulse on new value
   output logic             speed_reverse,                // Direction of last window
   output logic             over_range,                   // Last window above max speed
   output logic [31:0]      position_count,               // Signed edge position
   output logic [2:0]       window_ms                     // Active window length in ms
);
   pes_edge_if eif ();

   pes_edge_qual u_qual (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .eif     (eif)
   );

   function automatic logic [1:0] max_mult(input logic [2:0] typ);
      max_mult = (typ == ENC_T1 || typ == ENC_T1A) ? MULT_4X :
                 (typ == ENC_T2) ? MULT_2X : MULT_1X;
   endfunction

   function automatic logic [2:0] mult_fac(input logic [1:0] m);
      mult_fac = (m == MULT_4X) ? 3'h4 : (m == MULT_2X) ? 3'h2 : 3'h1;
   endfunction

   logic [CNT_W-1:0] win_cnt_ff;
   logic [CNT_W-1:0] raw_a_ff;
   logic [CNT_W-1:0] cnt_lat_ff;
   logic [TMR_W-1:0] tmr_ff;
   logic [1:0]       mult_win_ff;
   logic [2:0]       win_ms_ff;
   logic             low_ff;
   logic signed [CNT_W:0] net_ff;
   logic [DIV_W-1:0] den_ff;
   logic [DIV_W-1:0] quo_ff;
   logic [DIV_W:0]   rem_ff;
   logic [5:0]       step_ff;
   pes_div_st_t      dv_ff;
   pes_div_st_t      nxt_dv;
   logic [15:0]      speed_ff;
   logic             upd_ff;
   logic             rev_ff;
   logic             ovr_ff;
   logic [31:0]      pos_ff;

   wire enc_on = (encoder_type_select != ENC_OFF) && (encoder_type_select <= ENC_T3);
   wire quad   = (encoder_type_select == ENC_T1) || (encoder_type_select == ENC_T1A);

   // Requested multiplicity is clamped to what the encoder type permits
   wire [1:0] req_mult  = (edge_multiplicity_select > MULT_4X) ? MULT_1X : edge_multiplicity_select;
   wire [1:0] lim_mult  = (req_mult > max_mult(encoder_type_select)) ?
                          max_mult(encoder_type_select) : req_mult;
   wire [1:0] nxt_mult  = (auto_multiplicity_switchover && low_ff) ?
                          max_mult(encoder_type_select) : lim_mult;

   assign eif.trk_a = track_a;
   assign eif.trk_b = track_b;
   assign eif.mult  = mult_win_ff;

   wire edge_ok = enc_on && eif.edge_q;
   wire step_up = quad ? eif.up : 1'b1;

   // Next window length; a very slow count reaches 4 ms, a slow one doubles a 1 or 2 ms base
   wire [2:0] base_ms = (measuring_window_select == WSEL_4MS) ? 3'h4 :
                        (measuring_window_select == WSEL_2MS) ? 3'h2 : 3'h1;
   wire cnt_low  = win_cnt_ff < CNT_W'(LOW_EDGES);
   wire cnt_vlow = win_cnt_ff < CNT_W'(VLOW_EDGES);
   wire [2:0] nxt_ms = !auto_window_switchover ? base_ms :
                       (base_ms == 3'h1 && cnt_vlow) ? 3'h4 :
                       (base_ms != 3'h4 && cnt_low) ? (base_ms << 1) : base_ms;

   wire [TMR_W-1:0] win_cyc = TMR_W'(WIN_1MS_CYC) * TMR_W'(win_ms_ff);
   // Window closes on the first gating sync after the nominal time has run out
   wire win_close = (tmr_ff >= win_cyc - TMR_W'(1)) && gate_sync;
   // Single-track edge rate above the encoder limit means speed above nmax
   wire [CNT_W-1:0] a_limit = CNT_W'(EDGE_LIMIT_PER_MS) * CNT_W'(win_ms_ff);

   wire [DIV_W-1:0] nxt_num = DIV_W'(win_cnt_ff) * SPEED_SCALE;
   wire [DIV_W-1:0] nxt_den = DIV_W'(mult_fac(mult_win_ff)) * DIV_W'(pulses_per_revolution) *
                              DIV_W'(win_ms_ff) * DIV_W'(max_speed_setting);
   wire [DIV_W:0]   trial   = {rem_ff[DIV_W-1:0], quo_ff[DIV_W-1]};
   wire             fits    = trial >= {1'b0, den_ff};
   wire [15:0]      sat_q   = (|quo_ff[DIV_W-1:16]) ? 16'hFFFF : quo_ff[15:0];
   wire             too_slow = cnt_lat_ff < MIN_EDGES;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tmr_ff      <= '0;
         win_cnt_ff  <= '0;
         raw_a_ff    <= '0;
         net_ff      <= '0;
         cnt_lat_ff  <= '0;
         mult_win_ff <= MULT_1X;
         win_ms_ff   <= 3'h1;
         low_ff      <= 1'b0;
         ovr_ff      <= 1'b0;
         rev_ff      <= 1'b0;
      end else if (win_close) begin
         tmr_ff      <= '0;
         win_cnt_ff  <= CNT_W'(edge_ok);
         raw_a_ff    <= CNT_W'(enc_on && eif.rise_a);
         net_ff      <= edge_ok ? (step_up ? 16'sh0001 : -16'sh0001) : 16'sh0000;
         cnt_lat_ff  <= win_cnt_ff;
         mult_win_ff <= nxt_mult;
         win_ms_ff   <= nxt_ms;
         low_ff      <= cnt_low;
         ovr_ff      <= raw_a_ff > a_limit;
         rev_ff      <= net_ff < 0;
      end else begin
         tmr_ff      <= (tmr_ff == {TMR_W{1'b1}}) ? tmr_ff : tmr_ff + TMR_W'(1);
         if (edge_ok && !(&win_cnt_ff)) begin
            win_cnt_ff <= win_cnt_ff + CNT_W'(1);
            net_ff     <= step_up ? net_ff + 16'sh0001 : net_ff - 16'sh0001;
         end
         if (enc_on && eif.rise_a && !(&raw_a_ff))
            raw_a_ff <= raw_a_ff + CNT_W'(1);
      end
   end

   // Sequential restoring divider; the window is far longer than its run
   always_comb begin
      case (dv_ff)
         DV_IDLE: nxt_dv = win_close ? DV_RUN : DV_IDLE;
         DV_RUN:  nxt_dv = (step_ff == 6'(DIV_W - 1)) ? DV_DONE : DV_RUN;
         DV_DONE: nxt_dv = DV_IDLE;
         default: nxt_dv = DV_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dv_ff   <= DV_IDLE;
         step_ff <= '0;
         den_ff  <= '0;
         quo_ff  <= '0;
         rem_ff  <= '0;
      end else begin
         dv_ff <= nxt_dv;
         if (dv_ff == DV_IDLE && win_close) begin
            den_ff  <= nxt_den;
            quo_ff  <= nxt_num;
            rem_ff  <= '0;
            step_ff <= '0;
         end else if (dv_ff == DV_RUN) begin
            rem_ff  <= fits ? trial - {1'b0, den_ff} : trial;
            quo_ff  <= {quo_ff[DIV_W-2:0], fits};
            step_ff <= step_ff + 6'h01;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         speed_ff <= 16'h0000;
         upd_ff   <= 1'b0;
         pos_ff   <= 32'h0000_0000;
      end else begin
         upd_ff <= (dv_ff == DV_DONE) && enc_on;
         if (!enc_on)
            speed_ff <= 16'h0000;
         else if (dv_ff == DV_DONE)
            speed_ff <= too_slow ? 16'h0000 : sat_q;
         if (edge_ok)
            pos_ff <= step_up ? pos_ff + 32'h0000_0001 : pos_ff - 32'h0000_0001;
      end
   end

   assign actual_speed_percent = speed_ff;
   assign speed_update         = upd_ff;
   assign speed_reverse        = rev_ff;
   assign over_range           = ovr_ff;
   assign position_count       = pos_ff;
   assign window_ms            = win_ms_ff;

   property p_off_zero;
      @(posedge mclk) disable iff (sys_rst)
      (encoder_type_select == ENC_OFF) |=> (actual_speed_percent == 16'h0000);
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("speed not zero while disabled");

   property p_single_rise;
      @(posedge mclk) disable iff (sys_rst)
      (mult_win_ff == MULT_1X && eif.edge_q) |-> (track_a && !$past(track_a));
   endproperty
   a_single_rise: assert property (p_single_rise) else $error("1x counted a non-rising edge");

   property p_2x_types;
      @(posedge mclk) disable iff (sys_rst)
      (win_close && encoder_type_select == ENC_T3) |=> (mult_win_ff == MULT_1X);
   endproperty
   a_2x_types: assert property (p_2x_types) else $error("2x used on type 3");

   property p_4x_types;
      @(posedge mclk) disable iff (sys_rst)
      (win_close && !quad) |=> (mult_win_ff != MULT_4X);
   endproperty
   a_4x_types: assert property (p_4x_types) else $error("4x used on non-quadrature type");

   property p_zero_below_min;
      @(posedge mclk) disable iff (sys_rst)
      speed_update && (cnt_lat_ff < MIN_EDGES) |-> (actual_speed_percent == 16'h0000);
   endproperty
   a_zero_below_min: assert property (p_zero_below_min) else $error("nonzero speed below minimum");

   property p_win_len;
      @(posedge mclk) disable iff (sys_rst)
      win_close |-> (tmr_ff == win_cyc - TMR_W'(1)) || (tmr_ff >= win_cyc);
   endproperty
   a_win_len: assert property (p_win_len) else $error("window closed early");

   property p_auto_win;
      @(posedge mclk) disable iff (sys_rst)
      (win_close && auto_window_switchover && measuring_window_select == WSEL_1MS && cnt_vlow)
      |=> (window_ms == 3'h4);
   endproperty
   a_auto_win: assert property (p_auto_win) else $error("very low speed did not select 4 ms");

   property p_fixed_win;
      @(posedge mclk) disable iff (sys_rst)
      (win_close && !auto_window_switchover && measuring_window_select == WSEL_1MS) |=> (window_ms == 3'h1);
   endproperty
   a_fixed_win: assert property (p_fixed_win) else $error("base window not 1 ms");

   property p_over;
      @(posedge mclk) disable iff (sys_rst)
      win_close && (raw_a_ff > a_limit) |=> over_range;
   endproperty
   a_over: assert property (p_over) else $error("over range not flagged");

   property p_pos;
      @(posedge mclk) disable iff (sys_rst)
      (edge_ok && step_up) |=> (position_count == $past(position_count) + 32'h0000_0001);
   endproperty
   a_pos: assert property (p_pos) else $error("position did not follow edge");

   property p_div_lat;
      @(posedge mclk) disable iff (sys_rst)
      (win_close && dv_ff == DV_IDLE) |-> ##49 (dv_ff == DV_DONE) ##1 (speed_update == $past(enc_on));
   endproperty
   a_div_lat: assert property (p_div_lat) else $error("speed result late");

   c_update:  cover property (@(posedge mclk) disable iff (sys_rst) speed_update && actual_speed_percent != 16'h0000);
   c_4x:      cover property (@(posedge mclk) disable iff (sys_rst) mult_win_ff == MULT_4X && eif.edge_q);
   c_auto4ms: cover property (@(posedge mclk) disable iff (sys_rst) window_ms == 3'h4 && auto_window_switchover);
   c_over:    cover property (@(posedge mclk) disable iff (sys_rst) over_range);
endmodule
`default_nettype wire

// *** rtl/pes_speed_notes_unused.sv ***
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** tb/pes_enc_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pes_enc_model (
   input  wire logic        mclk,    // System clock
   input  wire logic        run,     // Shaft turning
   input  wire logic        reverse, // Track B leads track A when set
   input  wire logic [15:0] quarter, // Cycles per quarter step
   output logic             track_a, // Track A
   output logic             track_b  // Track B
);
   logic [15:0] tick;
   logic [1:0]  phase;
   wire  [15:0] q_lim;

   // Quarter steps never shorter than one cycle keep the track rate bounded
   assign q_lim = (quarter == 16'h0000) ? 16'h0001 : quarter;

   initial begin
      tick  = 16'h0000;
      phase = 2'h0;
   end

   always @(posedge mclk) begin
      if (run) begin
         if (tick + 16'h0001 >= q_lim) begin
            tick  <= 16'h0000;
            phase <= reverse ? phase - 2'h1 : phase + 2'h1;
         end else begin
            tick <= tick + 16'h0001;
         end
      end
   end

   // Forward order 00,10,11,01 puts A ahead of B; a stopped shaft holds its levels
   assign track_a = (phase == 2'h1) || (phase == 2'h2);
   assign track_b = phase[1];
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
   checks++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); \
   end \
end
module tb;
   import pes_pkg::*;
   localparam int unsigned WIN = 100;
   logic        mclk, sys_rst, gate_sync, run, reverse, amul, awin;
   logic        upd, rev, ovr, upd2, ovr2;
   logic [15:0] quarter, max_spd, spd;
   logic [2:0]  etype, wms;
   logic [14:0] ppr;
   logic [1:0]  mult, wsel;
   logic [31:0] pos;
   wire logic   track_a, track_b;
   int          errors, checks, cyc;

   pes_enc_model enc (.mclk(mclk), .run(run), .reverse(reverse), .quarter(quarter),
      .track_a(track_a), .track_b(track_b));
   pes_speed #(.WIN_1MS_CYC(WIN)) dut (.mclk(mclk), .sys_rst(sys_rst), .track_a(track_a), .track_b(track_b),
      .gate_sync(gate_sync), .encoder_type_select(etype), .pulses_per_revolution(ppr),
      .max_speed_setting(max_spd), .edge_multiplicity_select(mult), .auto_multiplicity_switchover(amul),
      .auto_window_switchover(awin), .measuring_window_select(wsel), .actual_speed_percent(spd),
      .speed_update(upd), .speed_reverse(rev), .over_range(ovr), .position_count(pos), .window_ms(wms));
   // Longer windows make the over-range limit reachable with a one-cycle quarter step
   pes_speed #(.WIN_1MS_CYC(2000)) dut_long (.mclk(mclk), .sys_rst(sys_rst), .track_a(track_a),
      .track_b(track_b), .gate_sync(gate_sync), .encoder_type_select(etype), .pulses_per_revolution(ppr),
      .max_speed_setting(max_spd), .edge_multiplicity_select(mult), .auto_multiplicity_switchover(amul),
      .auto_window_switchover(awin), .measuring_window_select(wsel), .actual_speed_percent(),
      .speed_update(upd2), .speed_reverse(), .over_range(ovr2), .position_count(), .window_ms());

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 100000) begin
         errors++;
         final_report();
      end
   end

   function automatic logic [15:0] exp_spd(input longint cnt, input longint mul, input longint wm);
      longint q;
      q = cnt * 64'h0000_0001_65A0_BC00 / (mul * ppr * wm * max_spd);
      return (q > 64'h0000_0000_0000_FFFF) ? 16'hFFFF : q[15:0];
   endfunction

   task automatic wait_upd(input int n, input bit sel = 1'b0);
      int k;
      k = 0;
      while (n > 0 && k < 20000) begin
         @(posedge mclk);
         #1;
         k++;
         if ((sel ? upd2 : upd) === 1'b1) n--;
      end
      if (n > 0) errors++;
   endtask

   // Settings change mid-window, so the first results after a change are mixed
   task automatic setup(input logic [2:0] t, input logic [1:0] m, input logic [1:0] w,
                        input logic [15:0] q, input logic dir);
      etype   = t;
      mult    = m;
      wsel    = w;
      quarter = q;
      reverse = dir;
      run     = (q != 16'h0000);
      wait_upd(3);
   endtask

   task automatic chk_pos(input logic [31:0] d);
      logic [31:0] p0;
      p0 = pos;
      repeat (WIN) @(posedge mclk);
      #1;
      `CHK(pos - p0, d)
   endtask

   task automatic t_modes();
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 3; j++) begin
            setup(ENC_T1, i[1:0], j[1:0], 16'h0005, 1'b0);
            wait_upd(1);
            `CHK(spd, exp_spd((5 << i) * (1 << j), 1 << i, 1 << j))
            `CHK(wms, 3'(1 << j))
            chk_pos(32'(5 << i));
         end
      end
   endtask

   task automatic t_types();
      setup(ENC_T2, MULT_4X, WSEL_1MS, 16'h0005, 1'b1);
      chk_pos(32'h0000_000A);
      setup(ENC_T3, MULT_4X, WSEL_1MS, 16'h0005, 1'b1);
      chk_pos(32'h0000_0005);
      setup(ENC_T1A, MULT_4X, WSEL_1MS, 16'h0005, 1'b1);
      chk_pos(32'hFFFF_FFEC);
      `CHK(rev, 1'b1)
   endtask

   task automatic t_off();
      etype = ENC_OFF;
      repeat (2) @(posedge mclk);
      #1;
      `CHK(spd, 16'h0000)
      chk_pos(32'h0000_0000);
      etype = 3'h5;
      chk_pos(32'h0000_0000);
   endtask

   task automatic t_limits();
      setup(ENC_T1, MULT_1X, WSEL_1MS, 16'h0000, 1'b0);
      `CHK(spd, 16'h0000)
      ppr     = 15'h7FFF;
      max_spd = 16'hFDE8;
      setup(ENC_T1, MULT_1X, WSEL_1MS, 16'h0019, 1'b0);
      `CHK(spd, exp_spd(1, 1, 1))
      ppr     = 15'h0001;
      max_spd = 16'h000A;
      setup(ENC_T1, MULT_4X, WSEL_1MS, 16'h0005, 1'b0);
      `CHK(spd, 16'hFFFF)
      ppr     = 15'h01F4;
      max_spd = 16'h1388;
      setup(ENC_T1, MULT_4X, WSEL_1MS, 16'h0001, 1'b0);
      wait_upd(3, 1'b1);
      `CHK(ovr2, 1'b1)
      setup(ENC_T1, MULT_4X, WSEL_1MS, 16'h0002, 1'b0);
      wait_upd(3, 1'b1);
      `CHK(ovr2, 1'b0)
   endtask

   task automatic t_auto();
      awin = 1'b1;
      setup(ENC_T1, MULT_1X, WSEL_1MS, 16'h0032, 1'b0);
      wait_upd(1);
      `CHK(wms, 3'h4)
      `CHK(spd, exp_spd(2, 1, 4))
      awin = 1'b0;
      amul = 1'b1;
      setup(ENC_T1, MULT_1X, WSEL_1MS, 16'h0019, 1'b0);
      chk_pos(32'h0000_0004);
      amul = 1'b0;
   endtask

   task automatic t_gate();
      int n;
      setup(ENC_T1, MULT_4X, WSEL_1MS, 16'h0005, 1'b0);
      gate_sync = 1'b0;
      n = 0;
      repeat (199) begin
         @(posedge mclk);
         #1;
         if (upd === 1'b1) n++;
      end
      `CHK(n, 0)
      gate_sync = 1'b1;
      n = 0;
      while (upd !== 1'b1 && n < 100) begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHK(n, 50)
   endtask

   // Reset while the shaft turns; release with track A high to probe for a false edge
   task automatic t_reset();
      int k;
      sys_rst = 1'b1;
      @(posedge mclk);
      #1;
      k = 0;
      while (track_a !== 1'b1 && k < 100) begin
         @(posedge mclk);
         #1;
         k++;
      end
      `CHK({upd, rev, ovr, pos, spd, wms}, 54'h1)
      sys_rst = 1'b0;
      @(posedge mclk);
      #1;
      `CHK(pos, 32'h0000_0000)
   endtask

   task automatic final_report();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      errors    = 0;
      checks    = 0;
      cyc       = 0;
      sys_rst   = 1'b1;
      gate_sync = 1'b1;
      run       = 1'b0;
      reverse   = 1'b0;
      amul      = 1'b0;
      awin      = 1'b0;
      quarter   = 16'h0005;
      etype     = ENC_OFF;
      mult      = MULT_1X;
      wsel      = WSEL_1MS;
      ppr       = 15'h01F4;
      max_spd   = 16'h1388;
      repeat (4) @(posedge mclk);
      #1;
      `CHK({upd, rev, ovr, pos, spd}, 51'h0)
      `CHK(wms, 3'h1)
      sys_rst = 1'b0;
      t_modes();
      t_types();
      t_off();
      t_limits();
      t_auto();
      t_gate();
      t_reset();
      final_report();
   end
endmodule
`default_nettype wire
